// ---- shared/acq_pkg.sv ----
package acq_pkg;
    // Command byte field positions
    localparam int CHAN_LSB      = 0;
    localparam int CHAN_W        = 4;
    localparam int TOPOLOGY_POS  = 4;
    localparam int LGAIN_POS     = 5;
    localparam int STYLE_POS     = 6;
    localparam int FILTER_POS    = 7;
    localparam int SLOT_LSB      = 0;
    localparam int SLOT_W        = 4;
    localparam int GGAIN_LSB     = 6;
    localparam int ADC_W         = 12;
    localparam logic [3:0] SLOT_COUNT  = 4'ha;
    localparam logic [3:0] DIFF_CHANS  = 4'h8;
    // Timing: conversion period at 62.5 kHz sample rate
    localparam int CLK_MHZ       = 100;
    localparam int CONV_NS       = 16000;
    localparam int CONV_CYCLES   = CONV_NS * CLK_MHZ / 1000;
    localparam logic [10:0] CONV_LAST = 11'(CONV_CYCLES - 1);

    typedef enum logic [1:0] {GAIN_X1, GAIN_X2, GAIN_X5, GAIN_X10} global_gain_e;

    typedef struct packed {
        logic       filter_2k;
        logic       acquire_style_bit;
        logic       local_gain_x10;
        logic       input_topology_bit;
        logic [3:0] channel;
    } first_cmd_s;

    typedef struct packed {
        global_gain_e gain;
        logic         unused_range;
        logic         read_mode;
        logic [3:0]   slot;
    } second_cmd_s;
endpackage : acq_pkg

// ---- logic/acquisition_front_end_control.sv ----
`timescale 1ns/1ps
// What this block does
// RQ1 - Inputs: sixteen single-ended or eight differential
// RQ2 - Exactly one local channel, last selected
// RQ3 - Local gain stage precedes slot multiplexer
// RQ4 - One of ten chassis slots passed
// RQ5 - Global gain one, two, five or ten
// RQ6 - Cutoff select 100 kHz or 2 kHz
// RQ7 - Twelve-bit result delivered toward host
// RQ8 - Previous result held in latches
// RQ9 - Latches refresh only on conversion finish
// RQ10 - External gate honoured only in auto mode
// RQ11 - Strap picks internal or external trigger
// RQ12 - Internal trigger: back-to-back free conversions
// RQ13 - Gate low runs, gate high suspends
// RQ14 - Host polls end-of-conversion status
// RQ15 - Style bit: 0 regular, 1 auto
// RQ16 - Topology bit: 1 single-ended, 0 differential
// RQ17 - Auto entry starts 62.5 kHz conversions
// RQ18 - Status low on finish, read clears
// RQ19 - Gate input through two-stage synchronizer
module acquisition_front_end_control
    import acq_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_first_cmd_wr,
    input  wire first_cmd_s        i_first_cmd,
    input  wire logic              i_second_cmd_wr,
    input  wire second_cmd_s       i_second_cmd,
    input  wire logic              i_start_wr,
    input  wire logic              i_data_rd,
    input  wire logic              i_trigger_source_strap,
    input  wire logic              i_ext_gate,
    input  wire logic              i_adc_done,
    input  wire logic [ADC_W-1:0]  i_adc_data,
    output logic                   o_single_ended,
    output logic [15:0]            o_local_select,
    output logic                   o_local_gain_x10,
    output logic [9:0]             o_slot_select,
    output global_gain_e           o_global_gain,
    output logic                   o_filter_2k,
    output logic                   o_auto_mode,
    output logic                   o_adc_start,
    output logic [15:0]            o_result,
    output logic                   o_eoc_n
);
    first_cmd_s  first_cmd;
    second_cmd_s second_cmd;
    logic        gate_meta;
    logic        gate_sync;
    logic        ext_sel;
    logic        busy;
    logic [10:0] pace;
    logic [ADC_W-1:0] result;
    logic        eoc;
    logic [10:0] since_start;
    logic        run_held;

    // One-hot decode used for both channel and slot muxes
    function automatic logic [15:0] onehot(input logic [3:0] idx);
        onehot = 16'h0001 << idx;
    endfunction : onehot

    // Command bytes; slot numbers ten and above are refused so the mux never goes dark
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            first_cmd  <= '0;
            second_cmd <= second_cmd_s'(8'h00);
        end else begin
            if (i_first_cmd_wr) begin
                first_cmd <= i_first_cmd; // RQ2 RQ15 RQ16
            end
            if (i_second_cmd_wr && i_second_cmd.slot < SLOT_COUNT) begin
                second_cmd <= i_second_cmd; // RQ4 RQ5
            end
        end
    end

    // Differential mode folds the channel number to the lower eight pairs
    wire logic [3:0] eff_chan = first_cmd.input_topology_bit ? first_cmd.channel
                               : {1'b0, first_cmd.channel[2:0]}; // RQ1
    wire logic [15:0] slot_hot = onehot(second_cmd.slot);
    assign o_single_ended   = first_cmd.input_topology_bit; // RQ16
    assign o_local_select   = onehot(eff_chan); // RQ2
    assign o_local_gain_x10 = first_cmd.local_gain_x10; // RQ3
    assign o_slot_select    = slot_hot[9:0]; // RQ4
    assign o_global_gain    = second_cmd.gain; // RQ5
    assign o_filter_2k      = first_cmd.filter_2k; // RQ6
    assign o_auto_mode      = first_cmd.acquire_style_bit; // RQ15

    // Gate is asynchronous; only the second stage is looked at
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            gate_meta <= 1'b1;
            gate_sync <= 1'b1;
        end else begin
            gate_meta <= i_ext_gate; // RQ19
            gate_sync <= gate_meta; // RQ19
        end
    end

    // Auto run permission: strap high means external gating
    assign ext_sel = i_trigger_source_strap; // RQ11
    wire logic auto_run = o_auto_mode && (!ext_sel || !gate_sync); // RQ10 RQ12 RQ13
    wire logic pace_due = (pace == CONV_LAST);
    // Regular mode starts on host command; gate plays no part there
    wire logic reg_start = !o_auto_mode && i_start_wr && !busy; // RQ10
    wire logic auto_start = auto_run && !busy && pace_due; // RQ17
    assign o_adc_start = reg_start || auto_start;

    // Pacing counter keeps auto starts at 16 us spacing
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !auto_run) begin
            pace <= CONV_LAST; // RQ17
        end else if (pace_due) begin
            pace <= pace_due && !busy ? 11'h000 : pace;
        end else begin
            pace <= pace + 11'h001;
        end
    end

    // Busy flag tracks converter activity between start and done
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            busy <= 1'b0;
        end else if (o_adc_start) begin
            busy <= 1'b1;
        end else if (i_adc_done) begin
            busy <= 1'b0;
        end
    end

    // Result latch and status; a finish in the same cycle as a read wins
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            result <= '0;
            eoc    <= 1'b0;
        end else begin
            if (i_adc_done) begin
                result <= i_adc_data; // RQ8 RQ9
                eoc    <= 1'b1; // RQ18
            end else if (i_data_rd) begin
                eoc    <= 1'b0; // RQ18 RQ14
            end
        end
    end

    assign o_result = {result, 4'h0}; // RQ7
    assign o_eoc_n  = !eoc; // RQ18

    // Cycles since the most recent start, held at its top value; lets the
    // spacing checks measure long gaps without a long delay range
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || o_adc_start) begin
            since_start <= 11'h000;
        end else if (since_start != 11'h7ff) begin
            since_start <= since_start + 11'h001;
        end
    end

    // High only while the auto run has lasted since its previous start; a
    // suspension restarts the pacing, so spacing is not judged across one
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !auto_run) begin
            run_held <= 1'b0;
        end else if (auto_start) begin
            run_held <= 1'b1;
        end
    end

    // Result, status, gating, pacing and selection checks
    chk_latch_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ9
        !i_adc_done |=> $stable(result)) else $error("Result changed without finish");
    chk_eoc_set: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ18
        i_adc_done |=> !o_eoc_n) else $error("Status not low after finish");
    chk_eoc_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ18
        i_data_rd && !i_adc_done |=> o_eoc_n) else $error("Read did not clear status");
    chk_gate_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ10
        !o_auto_mode |-> (o_adc_start == (i_start_wr && !busy)))
        else $error("Regular mode start wrong");
    chk_gate_suspend: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ13
        o_auto_mode && ext_sel && gate_sync |-> !o_adc_start)
        else $error("Start while gate high");
    chk_auto_pace: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ17
        auto_start |=> !o_adc_start [*8]) else $error("Auto starts too close");
    chk_sync_path: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ19
        !i_sys_rst ##1 !i_sys_rst |=> gate_sync == $past(i_ext_gate, 2))
        else $error("Gate sync depth wrong");
    chk_local_onehot: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ2
        $onehot(o_local_select)) else $error("Local select not one-hot");
    chk_slot_onehot: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ4
        $onehot(o_slot_select)) else $error("Slot select not one-hot");
    chk_diff_range: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ1
        !o_single_ended |-> o_local_select[15:8] == 8'h00) else $error("Diff chan above 7");
    chk_result_pad: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ7
        o_result[3:0] == 4'h0) else $error("Low nibble not zero");

    // Command, pacing and refusal checks
    chk_auto_spacing: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ17
        auto_start && run_held |-> since_start >= CONV_LAST)
        else $error("Auto starts closer than the pacing period");
    chk_start_refused: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ17
        busy |-> !o_adc_start)
        else $error("Start while converter busy");
    chk_style_apply: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ15
        i_first_cmd_wr |=> o_auto_mode == $past(i_first_cmd.acquire_style_bit))
        else $error("Style bit not applied");
    chk_slot_refuse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ4
        i_second_cmd_wr && (i_second_cmd.slot >= SLOT_COUNT) |=> $stable(o_slot_select) && $stable(o_global_gain))
        else $error("Out-of-range slot byte taken");
    chk_strap_internal: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // RQ12
        o_auto_mode && !ext_sel && !busy && pace_due |-> o_adc_start)
        else $error("Internal trigger missed a start");

    // Main scenarios worth seeing
    cov_regular: cover property (@(posedge i_sys_clk)
        !o_auto_mode && busy && i_adc_done && since_start < CONV_LAST);
    cov_auto_int: cover property (@(posedge i_sys_clk) auto_start && !ext_sel);
    cov_auto_ext: cover property (@(posedge i_sys_clk) auto_start && ext_sel);
    cov_set_clear: cover property (@(posedge i_sys_clk) i_adc_done && i_data_rd);
endmodule : acquisition_front_end_control

// ---- tb/adc_model.sv ----
`timescale 1ns/1ps
module adc_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_start,
    output logic             o_done,
    output logic [11:0]      o_data
);
    int          cnt  = 0;
    logic [11:0] val  = 12'h5a3;
    initial o_done = 1'b0;
    // Fixed 40-cycle conversion; a new value each time so stale data shows
    always @(posedge i_sys_clk) begin
        o_done <= (cnt == 1);
        if (i_start) cnt <= 40;
        else if (cnt != 0) cnt <= cnt - 1;
        if (cnt == 1) val <= val + 12'h111;
    end
    // Data is only valid with done; show the inverse otherwise
    assign o_data = o_done ? val : ~val;
endmodule : adc_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import acq_pkg::*;
    logic clk = 0, rst = 1, fw = 0, sw = 0, st = 0, rd = 0, strap = 0, gate = 1;
    first_cmd_s   fc = '0;
    second_cmd_s  sc = '0;
    logic done, se, lg, f2k, am, as, eoc;
    logic [11:0] ad, last;
    logic [15:0] lsel, res;
    logic [9:0]  ssel;
    global_gain_e gg;
    int failures = 0, checked = 0, n;
    always #5 clk = ~clk;
    acquisition_front_end_control DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_first_cmd_wr(fw),
        .i_first_cmd(fc), .i_second_cmd_wr(sw), .i_second_cmd(sc), .i_start_wr(st),
        .i_data_rd(rd), .i_trigger_source_strap(strap), .i_ext_gate(gate), .i_adc_done(done),
        .i_adc_data(ad), .o_single_ended(se), .o_local_select(lsel), .o_local_gain_x10(lg),
        .o_slot_select(ssel), .o_global_gain(gg), .o_filter_2k(f2k), .o_auto_mode(am),
        .o_adc_start(as), .o_result(res), .o_eoc_n(eoc));
    adc_model conv (.i_sys_clk(clk), .i_start(as), .o_done(done), .o_data(ad));
    // Remember the value the converter handed over last
    always @(posedge clk) if (done) last <= ad;
    task chk(string nm, logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task w1(first_cmd_s c);
        @(posedge clk) begin fc <= c; fw <= 1; end
        @(posedge clk) fw <= 0;
        #1;
    endtask : w1
    task w2(second_cmd_s c);
        @(posedge clk) begin sc <= c; sw <= 1; end
        @(posedge clk) sw <= 0;
        #1;
    endtask : w2
    // Bounded wait for a start pulse; running out is a failure and ends the run
    task wait_start(int lim);
        n = 0;
        while (as !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (as !== 1'b1) begin
            chk("start_timeout", as, 1);
            conclude;
        end
    endtask : wait_start
    // Bounded wait for the status to go low; running out ends the run
    task wait_eoc(int lim);
        n = 0;
        #1;
        while (eoc !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (eoc !== 1'b0) begin
            chk("eoc_timeout", eoc, 0);
            conclude;
        end
    endtask : wait_eoc
    task t_cmd;
        chk("eoc_rst", eoc, 1);
        chk("res_rst", res, 0);
        w1(8'h35);
        chk("sel_se", lsel, 16'h0020);
        chk("se", se, 1);
        chk("lgain", lg, 1);
        w1(8'h8d);
        chk("sel_diff", lsel, 16'h0020);
        chk("se_off", se, 0);
        chk("filt", f2k, 1);
        for (int g = 0; g < 4; g++) begin
            w2({g[1:0], 2'b00, 4'h9});
            chk("slot9", ssel, 10'h200);
            chk("gain", gg, g);
        end
        w2(8'h0a);
        chk("slot_refused", ssel, 10'h200);
        w2(8'h00);
        chk("slot0", ssel, 10'h001);
    endtask : t_cmd
    task t_regular;
        @(posedge clk) st <= 1;
        @(posedge clk) st <= 0;
        wait_eoc(100);
        chk("eoc_low", eoc, 0);
        chk("result", res, {last, 4'h0});
        @(posedge clk) begin rd <= 1; st <= 1; end
        @(posedge clk) begin rd <= 0; st <= 0; end
        #1;
        chk("eoc_clear", eoc, 1);
        repeat (10) @(posedge clk);
        chk("held", res, {last, 4'h0});
    endtask : t_regular
    task t_auto;
        w1(8'h40);
        chk("auto", am, 1);
        wait_start(100);
        chk("auto_go", n < 100, 1);
        @(posedge clk);
        #1;
        wait_start(2000);
        chk("pace", n, 1599);
        @(posedge clk) begin strap <= 1; gate <= 1; end
        repeat (5) @(posedge clk);
        // Count starts over a long stretch; the host strobe must be ignored too
        n = 0;
        for (int k = 0; k < 1700; k++) begin
            @(posedge clk) st <= (k == 10);
            #1;
            if (as === 1'b1) n++;
        end
        chk("suspend", n, 0);
        @(posedge clk) gate <= 0;
        wait_start(1700);
        chk("resume", n, 2);
        @(posedge clk) rd <= 1;
        @(posedge clk) rd <= 0;
        wait_eoc(100);
        chk("auto_eoc", eoc, 0);
        chk("auto_result", res, {last, 4'h0});
    endtask : t_auto
    // Mid-run reset must bring every command and the status back to idle
    task t_reset;
        @(posedge clk) rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        #1;
        chk("rst_auto", am, 0);
        chk("rst_eoc", eoc, 1);
        chk("rst_res", res, 0);
        chk("rst_sel", lsel, 16'h0001);
        chk("rst_slot", ssel, 10'h001);
        chk("rst_gain", gg, GAIN_X1);
    endtask : t_reset
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        t_cmd;
        t_regular;
        t_auto;
        t_reset;
        conclude;
    end
    // Hard stop in case a wait above misbehaves
    initial begin
        #500000;
        failures++;
        conclude;
    end
endmodule : tb_top
